// ==== bench/device_model.sv ====
`timescale 1ns/1ps
module device_model
    import offline_io_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] readPhaseCounter,
    input wire logic [7:0] charValue,
    input wire logic [3:0] lateCycles,
    output logic devStrobe,
    output logic [7:0] devData
);
    logic [3:0] waitCount;

    ////////////////////////////////////////////////////////////////////////////////
    // The device answers a read request after a chosen delay and holds the character
    // until the reader leaves its strobe phase. A released line shows the inverse of
    // its last value so that no stale character can pass for a fresh one.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            devStrobe <= 1'b0;
            devData <= 8'h00;
            waitCount <= 4'h0;
        end else if (readPhaseCounter == RP_PH1) begin
            if (waitCount == lateCycles) begin
                devStrobe <= 1'b1;
                devData <= charValue;
            end else begin
                waitCount <= waitCount + 4'h1;
            end
        end else begin
            waitCount <= 4'h0;
            devStrobe <= 1'b0;
            devData <= ~devData;
        end
    end
endmodule : device_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
    checkCount++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module tb
    import offline_io_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] wbAdr = 4'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [3:0] wbSel = 4'h0;
    logic wbWe = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic [31:0] wbDatO;
    logic wbAck;
    logic clearExternalSync = 1'b0;
    logic inputCharTaken = 1'b0;
    logic charInOutputHolding = 1'b0;
    logic endBlockMarkSeen = 1'b0;
    logic devStrobe;
    logic [7:0] devData;
    logic [7:0] devChar = 8'h07;
    logic [3:0] lateCycles = 4'h3;
    logic [5:0] stepSequencer;
    logic [2:0] readPhaseCounter;
    logic [7:0] inputCharHolding;
    logic charInInputHolding;
    logic cancel;
    logic outputCharDone;
    logic countRequest;
    logic goFlag;
    logic reverseFlag;
    logic writeControlFlag;
    logic haltFlag;
    logic programCounterLoad;
    logic [5:0] programCounterValue;
    logic [31:0] rd;
    logic [13:0] modeCtrl [4] = '{14'h0008, 14'h0082, 14'h0020, 14'h0040};
    logic modeRev [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic modeWc [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int fails = 0;
    int checkCount = 0;
    int cycles = 0;
    int n;

    always #12.5 clk = ~clk;

    offline_io_sequencer dut_u (.clk(clk), .rst_n(rst_n), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
        .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .clearExternalSync(clearExternalSync), .inputCharTaken(inputCharTaken),
        .charInOutputHolding(charInOutputHolding), .endBlockMarkSeen(endBlockMarkSeen),
        .devStrobe(devStrobe), .devData(devData), .stepSequencer(stepSequencer),
        .readPhaseCounter(readPhaseCounter), .inputCharHolding(inputCharHolding),
        .charInInputHolding(charInInputHolding), .cancel(cancel),
        .outputCharDone(outputCharDone), .countRequest(countRequest), .goFlag(goFlag),
        .reverseFlag(reverseFlag), .writeControlFlag(writeControlFlag), .haltFlag(haltFlag),
        .programCounterLoad(programCounterLoad), .programCounterValue(programCounterValue));

    device_model dev_u (.clk(clk), .rst_n(rst_n), .readPhaseCounter(readPhaseCounter),
        .charValue(devChar), .lateCycles(lateCycles), .devStrobe(devStrobe), .devData(devData));

    task automatic end_of_test();
        if (fails == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One classic bus cycle; ack and read data are taken at the same rising edge.
    task automatic wb(input logic [3:0] adr, input logic we, input logic [31:0] dat,
        input logic [3:0] sel, output logic [31:0] data);
        wbAdr <= adr;
        wbWe <= we;
        wbDatI <= dat;
        wbSel <= sel;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        do @(posedge clk); while (wbAck !== 1'b1);
        data = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic start(input logic [13:0] ctrl);
        wb(ADR_CTRL, 1'b1, {18'h0, ctrl}, 4'h3, rd);
        wb(ADR_CMD, 1'b1, 32'h1, 4'h1, rd);
    endtask : start

    task automatic wait_state(input logic [5:0] s);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (stepSequencer !== s && n < 3000);
        if (n >= 3000) fails++;
    endtask : wait_state

    task automatic next_phase(input logic [2:0] exp);
        logic [2:0] prev;
        prev = readPhaseCounter;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (readPhaseCounter === prev && n < 3000);
        `CHECK(readPhaseCounter, exp)
    endtask : next_phase

    task automatic clear_sync();
        clearExternalSync <= 1'b1;
        @(posedge clk);
        clearExternalSync <= 1'b0;
        @(posedge clk);
        `CHECK({stepSequencer, readPhaseCounter}, 9'h000)
        `CHECK({goFlag, reverseFlag, writeControlFlag}, 3'b000)
    endtask : clear_sync

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHECK({stepSequencer, readPhaseCounter, goFlag}, 10'h000)
        wb(ADR_STATUS, 1'b0, 32'h0, 4'hf, rd);
        `CHECK(rd, 32'h0)
        wb(4'h2, 1'b1, 32'hffff, 4'hf, rd);
        wb(4'h2, 1'b0, 32'h0, 4'hf, rd);
        `CHECK(rd, 32'h0)
        wb(ADR_CTRL, 1'b0, 32'h0, 4'hf, rd);
        `CHECK(rd, 32'h0)
        // Flags set in state one for paper tape, tape output, backspace and erase starts.
        for (int i = 0; i < 4; i++) begin
            start(modeCtrl[i]);
            wait_state(SQ_ERASE_FIRST);
            `CHECK({goFlag, reverseFlag, writeControlFlag}, {1'b1, modeRev[i], modeWc[i]})
            @(posedge clk);
            `CHECK(countRequest, modeCtrl[i][CT_ERASE])
            clear_sync();
        end
        // Free stepping of a card run: one state per timing pulse, cancel at the first mark.
        start(14'h0004);
        wait_state(6'h03);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (stepSequencer === 6'h03 && n < 300);
        `CHECK(n, STEP_CYC)
        `CHECK(stepSequencer, 6'h04)
        wait_state(SQ_FIRST_MARK);
        repeat (2) @(posedge clk);
        `CHECK(cancel, 1'b1)
        clear_sync();
        // Card read with a good character, then internal control takes it.
        lateCycles <= 4'hc;
        devChar <= 8'h07;
        start(14'h0004);
        for (int p = 1; p < 8; p++) begin
            next_phase(3'(p));
        end
        `CHECK(charInInputHolding, 1'b1)
        `CHECK(inputCharHolding, 8'h07)
        wb(ADR_DATA, 1'b0, 32'h0, 4'hf, rd);
        `CHECK(rd[7:0], 8'h07)
        inputCharTaken <= 1'b1;
        next_phase(RP_PH7);
        inputCharTaken <= 1'b0;
        wb(ADR_STATUS, 1'b0, 32'h0, 4'hf, rd);
        `CHECK(rd[ST_INPUT_DATA_ERROR_FLAG], 1'b0)
        clear_sync();
        // Paper tape character with bad parity and inhibit set traps the program.
        lateCycles <= 4'h0;
        devChar <= 8'h03;
        start(14'h0108);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (programCounterLoad !== 1'b1 && n < 3000);
        `CHECK(programCounterValue, PC_PARITY_TRAP)
        repeat (2) @(posedge clk);
        `CHECK({haltFlag, goFlag}, 2'b10)
        wb(ADR_STATUS, 1'b0, 32'h0, 4'hf, rd);
        `CHECK({rd[ST_HALT], rd[ST_INPUT_DATA_ERROR_FLAG]}, 2'b11)
        wb(ADR_STATUS, 1'b1, 32'h0005_0000, 4'h4, rd);
        wb(ADR_STATUS, 1'b0, 32'h0, 4'hf, rd);
        `CHECK({rd[ST_HALT], rd[ST_INPUT_DATA_ERROR_FLAG]}, 2'b00)
        clear_sync();
        end_of_test();
    end
endmodule : tb

// ==== rtl/offline_io_pkg.sv ====
package offline_io_pkg;
    // Clock and timing pulse spacing.
    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_TIME_NS = 2000;
    localparam int STEP_CYC = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int ALT_CYC = STEP_CYC / 2;
    localparam logic [6:0] STEP_LAST = 7'(STEP_CYC - 1);
    localparam logic [6:0] ALT_POINT = 7'(ALT_CYC - 1);

    // Memory address counter length.
    localparam int MAC_STATES = 336;
    localparam logic [8:0] MAC_LAST = 9'(MAC_STATES - 1);

    // Step sequencer landmark states.
    localparam logic [5:0] SQ_STANDBY = 6'h00;
    localparam logic [5:0] SQ_SELECT = 6'h01;
    localparam logic [5:0] SQ_ERASE_FIRST = 6'h02;
    localparam logic [5:0] SQ_START_FIRST = 6'h06;
    localparam logic [5:0] SQ_OUT_START_END = 6'h0b;
    localparam logic [5:0] SQ_START_LAST = 6'h0d;
    localparam logic [5:0] SQ_READ_START = 6'h0f;
    localparam logic [5:0] SQ_WRITE_LOOP = 6'h10;
    localparam logic [5:0] SQ_OUT_DONE = 6'h11;
    localparam logic [5:0] SQ_FIRST_MARK = 6'h12;
    localparam logic [5:0] SQ_WRITE_X_FIRST = 6'h14;
    localparam logic [5:0] SQ_WRITE_X_LAST = 6'h1e;
    localparam logic [5:0] SQ_FAST_LAST = 6'h21;
    localparam logic [5:0] SQ_END_MARK = 6'h22;
    localparam logic [5:0] SQ_STOP_FIRST = 6'h28;
    localparam logic [5:0] SQ_STOP_EARLY = 6'h2c;
    localparam logic [5:0] SQ_STOP_LAST = 6'h37;
    localparam logic [5:0] SQ_ERASE_LAST = 6'h38;

    // Read phase counter codes.
    localparam logic [2:0] RP_STANDBY = 3'h0;
    localparam logic [2:0] RP_PH7 = 3'h1;
    localparam logic [2:0] RP_PH1 = 3'h2;
    localparam logic [2:0] RP_PH5 = 3'h6;
    localparam logic [2:0] RP_PH6 = 3'h7;

    localparam logic [5:0] PC_PARITY_TRAP = 6'h0e;

    // Register offsets.
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_CMD = 4'h4;
    localparam logic [3:0] ADR_STATUS = 4'h8;
    localparam logic [3:0] ADR_DATA = 4'hc;

    // Control register fields.
    localparam int CT_IMT = 0;
    localparam int CT_OMT = 1;
    localparam int CT_ICD = 2;
    localparam int CT_IPT = 3;
    localparam int CT_OCP = 4;
    localparam int CT_BACK = 5;
    localparam int CT_ERASE = 6;
    localparam int CT_OUTPUT = 7;
    localparam int CT_PINH = 8;
    localparam int CT_LOOP_LSB = 9;
    localparam int CT_ODD = 13;
    localparam logic [13:0] CTRL_RESET = 14'h0000;

    // Status register fields.
    localparam int ST_RP_LSB = 8;
    localparam int ST_INPUT_DATA_ERROR_FLAG = 16;
    localparam int ST_OUTPUT_DATA_ERROR_FLAG = 17;
    localparam int ST_HALT = 18;
    localparam int ST_GO = 19;
endpackage : offline_io_pkg

// ==== rtl/offline_io_sequencer.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Non-tape: sequencer keeps stepping until clear sync, then standby and flags clear.
// RULE2 - Tape stop interval timed in upper states like the start interval.
// RULE3 - Read phases accept a device char, check parity, signal char-in-holding.
// RULE4 - Ignored characters raise cancel toward internal control.
// RULE5 - Internal control raises char-taken when it copies the holding register.
// RULE6 - Read phase counter is three bits, steps every 2 us, idles in standby.
// RULE7 - Codes: 000 standby, 001 phase7, 010 phase1, 011 phase2, 100-111 phases 3-6.
// RULE8 - Phase six reloads phase seven on tape, char-taken or cancel.
// RULE9 - Erase counts full address counter cycles in a range of sequencer states.
// RULE10 - State one sets go, reverse for paper tape/backspace, write for output/erase.
// RULE11 - Start and stop ranges request counting and hold while interval level low.
// RULE12 - State 22 octal cancels the first block mark on input or backspace.
// RULE13 - State 42 octal with end mark cancels and sets input error.
// RULE14 - State 21 octal signals output done and waits for char-in-output.
// RULE15 - Write loop state 24-36 octal picks the tape write cycle time.
// RULE16 - States 17-41 octal advance on timing pulse and on alternate with A and B.
// RULE17 - B adds one microsecond; A and B clear after the extra step.
// RULE18 - Starting from standby clears A on the timing pulse.
// RULE19 - Paper tape parity fault with inhibit traps: program counter 14, halt, error.
// RULE20 - Phase five parity fault sets output or input error by direction.
// RULE21 - Sequencer steps every 2 us unless held; jumps hold then load.
// RULE22 - Address counter steps 336 states, 672 us per cycle, then wraps.
// RULE23 - Updates ride the timing pulses; reset forces both counters to standby.
module offline_io_sequencer
    import offline_io_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic clearExternalSync,
    input wire logic inputCharTaken,
    input wire logic charInOutputHolding,
    input wire logic endBlockMarkSeen,
    input wire logic devStrobe,
    input wire logic [7:0] devData,
    output logic [5:0] stepSequencer,
    output logic [2:0] readPhaseCounter,
    output logic [7:0] inputCharHolding,
    output logic charInInputHolding,
    output logic cancel,
    output logic outputCharDone,
    output logic countRequest,
    output logic goFlag,
    output logic reverseFlag,
    output logic writeControlFlag,
    output logic haltFlag,
    output logic programCounterLoad,
    output logic [5:0] programCounterValue
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [6:0] divReg;
    logic tp;
    logic qp;
    logic [8:0] macReg;
    logic tlmReg;
    logic [5:0] sqReg;
    logic [5:0] sqNext;
    logic [2:0] rpReg;
    logic [2:0] rpNext;
    logic aReg;
    logic bReg;
    logic startPending;
    logic [13:0] ctrlReg;
    logic idtfReg;
    logic odtfReg;
    logic [1:0] strobeSync;
    logic [7:0] dataMeta;
    logic [7:0] dataSync;

    // Timing pulse every 2 us and alternate pulse half way between.
    assign tp = (divReg == STEP_LAST);
    assign qp = (divReg == ALT_POINT);

    function automatic logic inRange(input logic [5:0] v, input logic [5:0] lo,
                                     input logic [5:0] hi);
        inRange = (v >= lo) && (v <= hi);
    endfunction : inRange

    wire tape_input_mode = ctrlReg[CT_IMT];
    wire tape_output_mode = ctrlReg[CT_OMT];
    wire card_input_mode = ctrlReg[CT_ICD];
    wire paper_tape_input_mode = ctrlReg[CT_IPT];
    wire card_punch_output_mode = ctrlReg[CT_OCP];
    wire back = ctrlReg[CT_BACK];
    wire erase = ctrlReg[CT_ERASE];
    wire outDir = ctrlReg[CT_OUTPUT];
    wire parityInhibit = ctrlReg[CT_PINH];
    wire tapeAny = tape_input_mode | tape_output_mode | back;
    wire readIn = tape_input_mode | card_input_mode | back;
    wire [5:0] loopState = SQ_WRITE_X_FIRST + {2'h0, ctrlReg[CT_LOOP_LSB +: 4]};
    wire inStart = inRange(sqReg, SQ_START_FIRST, SQ_START_LAST);
    wire inStop = inRange(sqReg, SQ_STOP_FIRST, SQ_STOP_LAST);
    wire inErase = inRange(sqReg, SQ_ERASE_FIRST, SQ_ERASE_LAST);
    wire inFast = inRange(sqReg, SQ_READ_START, SQ_FAST_LAST);

    // RULE11 tape count request
    wire countNext = ((inStart | inStop) & tapeAny) | (inErase & erase);
    // RULE11 hold on interval
    wire tapeHold = (inStart | inStop) & tapeAny & !tlmReg;
    // RULE9 erase cycle counting
    wire eraseHold = inErase & erase & !tlmReg;
    // RULE14 wait for next char
    wire outHold = (sqReg == SQ_OUT_DONE) & outDir & !charInOutputHolding;
    wire seqHold = tapeHold | eraseHold | outHold;

    wire jumpRead = tlmReg & (((sqReg == SQ_START_FIRST) & (tape_input_mode | back))
                              | ((sqReg == SQ_OUT_START_END) & tape_output_mode));
    // RULE2 stop interval end
    wire jumpStop = tlmReg & tape_input_mode & (sqReg == SQ_STOP_EARLY);
    // RULE15 write loop state
    wire atLoop = tape_output_mode & (sqReg == loopState) & inRange(sqReg, SQ_WRITE_X_FIRST,
                                                       SQ_WRITE_X_LAST);
    wire loopJump = atLoop & aReg & qp & (!ctrlReg[CT_ODD] | bReg);
    wire setB = atLoop & aReg & qp & ctrlReg[CT_ODD] & !bReg;
    wire extraStep = inFast & !atLoop & aReg & bReg & qp;

    // RULE12 first block mark
    wire cancelFirst = (sqReg == SQ_FIRST_MARK) & readIn;
    // RULE13 end mark cancel
    wire endMark = (sqReg == SQ_END_MARK) & (tape_input_mode | card_input_mode) & endBlockMarkSeen;
    // RULE4 cancel toward internal control
    wire cancelNext = cancelFirst | endMark;

    wire startRead = tp & (sqReg == SQ_READ_START) & (readIn | paper_tape_input_mode | card_punch_output_mode);
    // RULE3 parity check of held char
    wire parityFault = (rpReg == RP_PH5) & tp & !(^inputCharHolding);
    // RULE19 paper tape trap
    wire parityTrap = parityFault & paper_tape_input_mode & parityInhibit;

    ////////////////////////////////////////////////////////////////////////////////
    // RULE21 step, hold or forced load
    always_comb begin
        sqNext = sqReg;
        if (clearExternalSync) begin
            // RULE1 return to standby
            sqNext = SQ_STANDBY;
        end else if (tp) begin
            if (sqReg == SQ_STANDBY) begin
                if (startPending) begin
                    sqNext = SQ_SELECT;
                end
            end else if (jumpRead) begin
                sqNext = SQ_READ_START;
            end else if (jumpStop) begin
                sqNext = SQ_ERASE_LAST;
            end else if (!seqHold) begin
                sqNext = 6'(sqReg + 6'h01);
            end
        end else if (loopJump) begin
            sqNext = SQ_WRITE_LOOP;
        end else if (extraStep) begin
            // RULE16 extra advance on alternate
            sqNext = 6'(sqReg + 6'h01);
        end
    end

    // RULE7 phase codes
    always_comb begin
        rpNext = rpReg;
        if (clearExternalSync) begin
            rpNext = RP_STANDBY;
        end else if (tp) begin
            unique case (rpReg)
                RP_STANDBY: rpNext = startRead ? RP_PH7 : RP_STANDBY;
                RP_PH1: rpNext = strobeSync[1] ? 3'(rpReg + 3'h1) : rpReg;
                // RULE8 reload phase seven
                RP_PH6: rpNext = (tape_input_mode | tape_output_mode | inputCharTaken | cancel) ? RP_PH7 : rpReg;
                // RULE6 step every 2 us
                default: rpNext = 3'(rpReg + 3'h1);
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // RULE23 timing base and counters
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divReg <= 7'h00;
            sqReg <= SQ_STANDBY;
            rpReg <= RP_STANDBY;
        end else begin
            divReg <= tp ? 7'h00 : 7'(divReg + 7'h01);
            sqReg <= sqNext;
            rpReg <= rpNext;
        end
    end

    // RULE22 address counter cycle
    always_ff @(posedge clk) begin
        if (!rst_n || !countRequest) begin
            macReg <= 9'h000;
            tlmReg <= 1'b0;
        end else if (tp) begin
            macReg <= (macReg == MAC_LAST) ? 9'h000 : 9'(macReg + 9'h001);
            tlmReg <= (macReg == MAC_LAST);
        end
    end

    // Device pins pass two flip-flops first.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobeSync <= 2'h0;
            dataMeta <= 8'h00;
            dataSync <= 8'h00;
        end else begin
            strobeSync <= {strobeSync[0], devStrobe};
            dataMeta <= devData;
            dataSync <= dataMeta;
        end
    end

    // RULE17 odd microsecond flip-flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aReg <= 1'b0;
            bReg <= 1'b0;
        end else if (tp && sqReg == SQ_STANDBY && startPending) begin
            // RULE18 align with timing pulse
            aReg <= 1'b0;
            bReg <= 1'b0;
        end else if (qp) begin
            aReg <= !(aReg & bReg);
            bReg <= (bReg | setB) & !(aReg & bReg) & !loopJump;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control flip-flops and device-facing outputs.
    always_ff @(posedge clk) begin
        if (!rst_n || clearExternalSync) begin
            goFlag <= 1'b0;
            reverseFlag <= 1'b0;
            writeControlFlag <= 1'b0;
        end else if (parityTrap) begin
            goFlag <= 1'b0;
        end else if (tp && sqReg == SQ_SELECT) begin
            // RULE10 device selection flags
            goFlag <= 1'b1;
            reverseFlag <= paper_tape_input_mode | back;
            writeControlFlag <= tape_output_mode | erase;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stepSequencer <= SQ_STANDBY;
            readPhaseCounter <= RP_STANDBY;
            cancel <= 1'b0;
            charInInputHolding <= 1'b0;
            outputCharDone <= 1'b0;
            countRequest <= 1'b0;
            programCounterLoad <= 1'b0;
            programCounterValue <= 6'h00;
            inputCharHolding <= 8'h00;
        end else begin
            stepSequencer <= sqNext;
            readPhaseCounter <= rpNext;
            cancel <= cancelNext;
            // RULE3 char-in-holding to internal control
            charInInputHolding <= (rpNext == RP_PH6) & !cancelNext;
            outputCharDone <= (sqNext == SQ_OUT_DONE) & outDir;
            countRequest <= countNext;
            programCounterLoad <= parityTrap;
            if (parityTrap) begin
                programCounterValue <= PC_PARITY_TRAP;
            end
            if (tp && rpReg == RP_PH7) begin
                inputCharHolding <= 8'h00;
            end else if (tp && rpReg == RP_PH1 && strobeSync[1]) begin
                inputCharHolding <= dataSync;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus slave.
    wire busReq = wb_cyc_i & wb_stb_i & !wb_ack_o;
    wire busWr = busReq & wb_we_i;
    wire statusClr = busWr & (wb_adr_i == ADR_STATUS) & wb_sel_i[2];
    // RULE20 direction of error
    wire idtfSet = (tp & endMark) | parityTrap | (parityFault & (tape_input_mode | card_input_mode));
    wire odtfSet = parityFault & (tape_output_mode | card_punch_output_mode);
    wire startSet = busWr & (wb_adr_i == ADR_CMD) & wb_sel_i[0] & wb_dat_i[0];
    wire [31:0] statusWord = {12'h000, goFlag, haltFlag, odtfReg, idtfReg,
                              5'h00, rpReg, 2'h0, sqReg};
    wire [31:0] readWord = (wb_adr_i == ADR_CTRL) ? {18'h00000, ctrlReg} :
                           (wb_adr_i == ADR_STATUS) ? statusWord :
                           (wb_adr_i == ADR_DATA) ? {24'h000000, inputCharHolding} :
                           32'h00000000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrlReg <= CTRL_RESET;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? readWord : 32'h00000000;
            if (busWr && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
                ctrlReg[7:0] <= wb_dat_i[7:0];
            end
            if (busWr && wb_adr_i == ADR_CTRL && wb_sel_i[1]) begin
                ctrlReg[13:8] <= wb_dat_i[13:8];
            end
        end
    end

    // Sticky flags: a set in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idtfReg <= 1'b0;
            odtfReg <= 1'b0;
            haltFlag <= 1'b0;
            startPending <= 1'b0;
        end else begin
            idtfReg <= idtfSet | (idtfReg & !(statusClr & wb_dat_i[ST_INPUT_DATA_ERROR_FLAG]));
            odtfReg <= odtfSet | (odtfReg & !(statusClr & wb_dat_i[ST_OUTPUT_DATA_ERROR_FLAG]));
            haltFlag <= parityTrap | (haltFlag & !(statusClr & wb_dat_i[ST_HALT]));
            startPending <= startSet | (startPending & !(tp && sqReg == SQ_STANDBY));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_sync_clear: assert property (clearExternalSync |=> sqReg == SQ_STANDBY && !goFlag) // RULE1
        else $error("sequencer not in standby after clear");
    a_tape_hold: assert property (tp && !clearExternalSync && tapeHold && !jumpRead // RULE11
        |=> $stable(sqReg)) else $error("sequencer moved while interval low");
    a_rp_idle: assert property (rpReg == RP_STANDBY && !startRead && !clearExternalSync // RULE6
        |=> rpReg == RP_STANDBY) else $error("read counter left standby");
    a_rp_reload: assert property (tp && rpReg == RP_PH6 && inputCharTaken // RULE8
        && !clearExternalSync |=> rpReg == RP_PH7) else $error("phase six reload missed");
    a_mac_wrap: assert property (tp && countRequest && macReg == MAC_LAST // RULE22
        |=> macReg == 9'h000 && tlmReg) else $error("address counter did not wrap");
    a_select_go: assert property (tp && sqReg == SQ_SELECT && !clearExternalSync // RULE10
        && !parityTrap |=> goFlag && writeControlFlag == (tape_output_mode | erase))
        else $error("selection flags wrong");
    a_out_wait: assert property (outHold && tp && !clearExternalSync // RULE14
        |=> sqReg == SQ_OUT_DONE ##1 outputCharDone) else $error("output wait broken");
    a_end_error: assert property (tp && endMark |=> idtfReg && cancel) // RULE13
        else $error("end mark error not flagged");
    a_tick_gap: assert property (tp |=> !tp [*8]) // RULE23
        else $error("timing pulses too close");
    a_trap_pc: assert property (parityTrap |=> programCounterLoad // RULE19
        && programCounterValue == PC_PARITY_TRAP && haltFlag && !goFlag)
        else $error("parity trap incomplete");
endmodule : offline_io_sequencer
